// ---- rtl/pfsc_pkg.sv ----
// constants shared by the port sideband control block
package pfsc_pkg;
   // register byte offsets
   localparam logic [7:0] ADDR_CFG0 = 8'h00; // per-port config, 4 apart
   localparam logic [7:0] ADDR_PAUSE = 8'h20;
   localparam logic [7:0] ADDR_TXERR = 8'h24;
   localparam logic [7:0] ADDR_STAT = 8'h28;
   // per-port config field positions
   localparam int CFG_TXTHR_LSB = 0;
   localparam int CFG_EARLY_BIT = 12;
   localparam int CFG_RXTHR_LSB = 16;
   localparam int CFG_FD_BIT = 28;
   localparam int CFG_CRC_BIT = 29;
   localparam int CFG_PAD_BIT = 30;
   localparam int CFG_PZERO_BIT = 31;
   // status field positions
   localparam int STAT_TXRDY_LSB = 0;
   localparam int STAT_RXRDY_LSB = 8;
   localparam int STAT_DISC_LSB = 16;
   // reset values
   localparam logic [31:0] CFG_RST = 32'h6040_0040;
   localparam logic [15:0] PAUSE_RST = 16'hffff;
   // ahb transfer type bit that marks an active transfer
   localparam int HTRANS_ACT_BIT = 1;
endpackage

// ---- rtl/pfsc_port.sv ----
// one port's ready, discard and flow-control logic
`timescale 1ns/1ps
module pfsc_port
   import pfsc_pkg::*;
#(
   parameter int CNT_W = 9
) (
   // clock and reset
   input wire logic sys_clk,
   input wire logic rst_n,
   // configuration
   input wire logic [31:0] cfg,
   // fifo status
   input wire logic [CNT_W-1:0] tx_free,
   input wire logic [CNT_W-1:0] rx_used,
   input wire logic rx_last_in,
   input wire logic rx_hdr_in,
   input wire logic rx_err_drop,
   input wire logic tx_stop_err,
   // clears
   input wire logic err_clr,
   input wire logic disc_clr,
   // flow-control pin
   input wire logic flow_pin,
   // results
   output logic tx_ready_r,
   output logic rx_ready_r,
   output logic disc_r,
   output logic err_hold_r,
   output logic force_col_r,
   output logic pause_req_r,
   output logic pause_zero_r
);
   logic flow_m_r, flow_s_r, flow_d_r;
   logic flow_m_nxt, flow_s_nxt, flow_d_nxt;
   logic tx_ready_nxt, rx_ready_nxt, disc_nxt, err_hold_nxt;
   logic force_col_nxt, pause_req_nxt, pause_zero_nxt;
   logic fd;

   // elaboration check: the thresholds must fit their config fields
   if (CNT_W < 2 || CNT_W > 12) begin : g_bad_cnt_w
      $error("pfsc_port: CNT_W out of range");
   end

   assign fd = cfg[CFG_FD_BIT];

   // next-state for all port state
   always_comb begin
      flow_m_nxt = flow_pin; // first sync stage
      flow_s_nxt = flow_m_r;
      flow_d_nxt = flow_s_r;
      // set wins over clear on both sticky flags
      err_hold_nxt = (err_hold_r & ~err_clr) | tx_stop_err; // R12
      disc_nxt = (disc_r & ~disc_clr) | rx_err_drop; // R3
      tx_ready_nxt = (tx_free >= cfg[CFG_TXTHR_LSB +: CNT_W])
                     & ~err_hold_nxt; // R11 R12
      rx_ready_nxt = (rx_used >= cfg[CFG_RXTHR_LSB +: CNT_W]) // R13
                     | rx_last_in // R14
                     | (cfg[CFG_EARLY_BIT] & rx_hdr_in) // R15
                     | disc_nxt; // R16
      force_col_nxt = flow_s_r & ~fd; // R6
      pause_req_nxt = flow_s_r & ~flow_d_r & fd; // R7
      pause_zero_nxt = ~flow_s_r & flow_d_r & fd
                       & cfg[CFG_PZERO_BIT]; // R8
   end

   // registers, sampled on the bus clock
   always_ff @(posedge sys_clk) begin // R20
      if (!rst_n) begin
         flow_m_r <= 1'b0;
         flow_s_r <= 1'b0;
         flow_d_r <= 1'b0;
         tx_ready_r <= 1'b0;
         rx_ready_r <= 1'b0;
         disc_r <= 1'b0;
         err_hold_r <= 1'b0;
         force_col_r <= 1'b0;
         pause_req_r <= 1'b0;
         pause_zero_r <= 1'b0;
      end else begin
         flow_m_r <= flow_m_nxt;
         flow_s_r <= flow_s_nxt;
         flow_d_r <= flow_d_nxt;
         tx_ready_r <= tx_ready_nxt;
         rx_ready_r <= rx_ready_nxt;
         disc_r <= disc_nxt;
         err_hold_r <= err_hold_nxt;
         force_col_r <= force_col_nxt;
         pause_req_r <= pause_req_nxt;
         pause_zero_r <= pause_zero_nxt;
      end
   end

   // error stop keeps tx ready low until cleared
   property p_err_hold;
      @(posedge sys_clk) disable iff (!rst_n)
      tx_stop_err |=> !tx_ready_r && err_hold_r;
   endproperty
   a_err_hold: assert property (p_err_hold) // R12
      else $error("tx ready not held low after error stop");

   // discard shows as ready together with the discard flag
   property p_disc;
      @(posedge sys_clk) disable iff (!rst_n)
      rx_err_drop |=> disc_r && rx_ready_r;
   endproperty
   a_disc: assert property (p_disc) // R16
      else $error("discard not reported with rx ready");

   // pin rise in full duplex gives one pause request
   sequence s_flow_rise;
      !flow_s_r ##1 flow_s_r;
   endsequence
   property p_pause_on;
      @(posedge sys_clk) disable iff (!rst_n)
      s_flow_rise ##0 fd |=> pause_req_r ##1 !pause_req_r;
   endproperty
   a_pause_on: assert property (p_pause_on) // R7
      else $error("pause request missing after flow request");

   // held pin in half duplex forces collision
   property p_force_col;
      @(posedge sys_clk) disable iff (!rst_n)
      flow_s_r && !fd |=> force_col_r;
   endproperty
   a_force_col: assert property (p_force_col) // R6
      else $error("collision not forced in half duplex");

   // pause-zero only after the pin falls
   property p_pause_zero;
      @(posedge sys_clk) disable iff (!rst_n)
      pause_zero_r |-> $past(flow_d_r) && !$past(flow_s_r);
   endproperty
   a_pause_zero: assert property (p_pause_zero) // R8
      else $error("pause zero without flow release");
endmodule

// ---- rtl/pfsc_top.sv ----
// sideband control top: ahb registers, tx/rx qualifiers, ready report
//
// Decided for this implementation: the AHB-Lite slave port and the placing of the registers.
`timescale 1ns/1ps
// Functional notes
// R1 - asis with first word: no pad, no crc
// R2 - asis with last word: symbol, mii error; the code gives the mii error only while the port's crc enable bit is set
// R3 - errored partial packet dropped sets discard flag
// R4 - abort request flushes current receive packet
// R5 - abort only together with receive select
// R6 - flow request, half duplex: force collisions
// R7 - flow request, full duplex: pause frame
// R8 - flow release, if enabled: zero pause
// R9 - tx ready driven only while enable low
// R10 - rx ready driven only while enable low
// R11 - tx ready when free space meets threshold
// R12 - error stop holds tx ready until read
// R13 - rx ready when data meets threshold
// R14 - rx ready when last word present
// R15 - rx ready optionally when header present
// R16 - discard shown with rx ready and flag
// R17 - master marks first word on write
// R18 - master marks last word on write
// R19 - ready outputs released when not enabled
// R20 - everything sampled on bus clock edge
module pfsc_top
   import pfsc_pkg::*;
#(
   parameter int NPORT = 8,
   parameter int CNT_W = 9
) (
   // clock and reset
   input wire logic sys_clk,
   input wire logic rst_n,
   // ahb-lite slave
   input wire logic hsel,
   input wire logic [31:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic [2:0] hsize,
   input wire logic [31:0] hwdata,
   input wire logic hready,
   output logic hreadyout,
   output logic hresp,
   output logic [31:0] hrdata,
   // transmit write sideband
   input wire logic tx_wr,
   input wire logic [$clog2(NPORT)-1:0] tx_port,
   input wire logic tx_sop,
   input wire logic tx_eop,
   input wire logic tx_asis,
   // receive read sideband
   input wire logic rxsel_n,
   input wire logic [$clog2(NPORT)-1:0] rx_port,
   input wire logic rx_abort,
   // ready report
   input wire logic txctl_n,
   input wire logic rxctl_n,
   output logic [NPORT-1:0] tx_rdy,
   output logic [NPORT-1:0] tx_rdy_oe,
   output logic [NPORT-1:0] rx_rdy,
   output logic [NPORT-1:0] rx_rdy_oe,
   output logic rx_fail,
   // fifo status per port
   input wire logic [NPORT*CNT_W-1:0] tx_free,
   input wire logic [NPORT*CNT_W-1:0] rx_used,
   input wire logic [NPORT-1:0] rx_last_in,
   input wire logic [NPORT-1:0] rx_hdr_in,
   input wire logic [NPORT-1:0] rx_err_drop,
   input wire logic [NPORT-1:0] tx_stop_err,
   // flow-control pins, asynchronous
   input wire logic [NPORT-1:0] flow_req,
   // mac controls
   output logic [NPORT-1:0] tx_no_pad,
   output logic [NPORT-1:0] tx_no_crc,
   output logic [NPORT-1:0] tx_sym_err,
   output logic [NPORT-1:0] tx_mii_err,
   output logic [NPORT-1:0] rx_flush,
   output logic [NPORT-1:0] force_col,
   output logic [NPORT-1:0] pause_req,
   output logic [NPORT-1:0] pause_zero,
   output logic [15:0] pause_time
);
   localparam int PW = $clog2(NPORT);

   logic [31:0] cfg_r [NPORT];
   logic [31:0] cfg_nxt [NPORT];
   logic [15:0] pause_nxt;
   logic wr_pend_r, wr_pend_nxt;
   logic [7:0] wr_addr_r, wr_addr_nxt;
   logic [31:0] hrdata_nxt;
   logic acc, rd_txerr;
   logic [NPORT-1:0] asis_r, asis_nxt;
   logic [NPORT-1:0] sym_nxt, mii_nxt, flush_nxt;
   logic [NPORT-1:0] txr_nxt, txoe_nxt, rxr_nxt, rxoe_nxt;
   logic fail_nxt;
   logic [NPORT-1:0] txr_raw, rxr_raw, disc, err_hold, disc_clr;
   logic [NPORT-1:0] crc_en, pad_en;

   // elaboration check: status fields hold at most eight ports
   if (NPORT < 2 || NPORT > 8) begin : g_bad_nport
      $error("pfsc_top: NPORT out of range");
   end

   // per-port ready, discard and flow logic
   for (genvar i = 0; i < NPORT; i++) begin : g_port
      assign crc_en[i] = cfg_r[i][CFG_CRC_BIT];
      assign pad_en[i] = cfg_r[i][CFG_PAD_BIT];
      // a receive select on the port consumes its discard report
      assign disc_clr[i] = !rxsel_n && (rx_port == PW'(i));
      pfsc_port #(.CNT_W(CNT_W)) u_port (
         .sys_clk(sys_clk),
         .rst_n(rst_n),
         .cfg(cfg_r[i]),
         .tx_free(tx_free[i*CNT_W +: CNT_W]),
         .rx_used(rx_used[i*CNT_W +: CNT_W]),
         .rx_last_in(rx_last_in[i]),
         .rx_hdr_in(rx_hdr_in[i]),
         .rx_err_drop(rx_err_drop[i]),
         .tx_stop_err(tx_stop_err[i]),
         .err_clr(rd_txerr),
         .disc_clr(disc_clr[i]),
         .flow_pin(flow_req[i]),
         .tx_ready_r(txr_raw[i]),
         .rx_ready_r(rxr_raw[i]),
         .disc_r(disc[i]),
         .err_hold_r(err_hold[i]),
         .force_col_r(force_col[i]),
         .pause_req_r(pause_req[i]),
         .pause_zero_r(pause_zero[i])
      );
   end

   // ahb decode: zero wait, okay always, read data built in address phase
   assign acc = hsel && hready && htrans[HTRANS_ACT_BIT];
   assign rd_txerr = acc && !hwrite && (haddr[7:0] == ADDR_TXERR);

   always_comb begin
      wr_pend_nxt = acc && hwrite;
      wr_addr_nxt = acc ? haddr[7:0] : wr_addr_r;
      pause_nxt = pause_time;
      hrdata_nxt = 32'h0000_0000; // unmapped reads give zero
      for (int i = 0; i < NPORT; i++) begin
         cfg_nxt[i] = cfg_r[i];
         if (wr_pend_r && wr_addr_r == ADDR_CFG0 + 8'(4 * i)) begin
            cfg_nxt[i] = hwdata;
         end
         if (acc && !hwrite && haddr[7:0] == ADDR_CFG0 + 8'(4 * i)) begin
            hrdata_nxt = cfg_r[i];
         end
      end
      if (wr_pend_r && wr_addr_r == ADDR_PAUSE) begin
         pause_nxt = hwdata[15:0];
      end
      if (acc && !hwrite) begin
         case (haddr[7:0])
            ADDR_PAUSE: hrdata_nxt = {16'h0000, pause_time};
            ADDR_TXERR: hrdata_nxt = {24'h00_0000, 8'(err_hold)};
            ADDR_STAT: begin
               hrdata_nxt[STAT_TXRDY_LSB +: 8] = 8'(txr_raw);
               hrdata_nxt[STAT_RXRDY_LSB +: 8] = 8'(rxr_raw);
               hrdata_nxt[STAT_DISC_LSB +: 8] = 8'(disc);
            end
            default: ;
         endcase
      end
   end

   // transmit qualifiers, receive abort and ready report
   always_comb begin
      asis_nxt = asis_r;
      sym_nxt = '0;
      mii_nxt = '0;
      flush_nxt = '0;
      if (tx_wr && tx_sop) begin
         asis_nxt[tx_port] = tx_asis; // R1
      end
      if (tx_wr && tx_eop && tx_asis) begin
         sym_nxt[tx_port] = 1'b1; // R2
         mii_nxt[tx_port] = crc_en[tx_port]; // R2
      end
      // abort is only honoured with the select, as the master guarantees
      if (!rxsel_n && rx_abort) begin // R5
         flush_nxt[rx_port] = 1'b1; // R4
      end
      txoe_nxt = {NPORT{!txctl_n}}; // R19
      rxoe_nxt = {NPORT{!rxctl_n}}; // R19
      txr_nxt = txctl_n ? '0 : txr_raw; // R9
      rxr_nxt = rxctl_n ? '0 : rxr_raw; // R10
      fail_nxt = |disc; // R3 R16
   end

   // register stage for bus slave and sideband outputs
   always_ff @(posedge sys_clk) begin // R20
      if (!rst_n) begin
         for (int i = 0; i < NPORT; i++) begin
            cfg_r[i] <= CFG_RST;
         end
         pause_time <= PAUSE_RST;
         wr_pend_r <= 1'b0;
         wr_addr_r <= 8'h00;
         hrdata <= 32'h0000_0000;
         hreadyout <= 1'b1;
         hresp <= 1'b0;
         asis_r <= '0;
         tx_sym_err <= '0;
         tx_mii_err <= '0;
         rx_flush <= '0;
         tx_rdy <= '0;
         tx_rdy_oe <= '0;
         rx_rdy <= '0;
         rx_rdy_oe <= '0;
         rx_fail <= 1'b0;
         tx_no_pad <= '0;
         tx_no_crc <= '0;
      end else begin
         cfg_r <= cfg_nxt;
         pause_time <= pause_nxt;
         wr_pend_r <= wr_pend_nxt;
         wr_addr_r <= wr_addr_nxt;
         hrdata <= hrdata_nxt;
         hreadyout <= 1'b1;
         hresp <= 1'b0;
         asis_r <= asis_nxt;
         tx_sym_err <= sym_nxt;
         tx_mii_err <= mii_nxt;
         rx_flush <= flush_nxt;
         tx_rdy <= txr_nxt;
         tx_rdy_oe <= txoe_nxt;
         rx_rdy <= rxr_nxt;
         rx_rdy_oe <= rxoe_nxt;
         rx_fail <= fail_nxt;
         tx_no_pad <= asis_nxt | ~pad_en; // R1
         tx_no_crc <= asis_nxt | ~crc_en; // R1
      end
   end

   // first-word asis suppresses pad and crc from the next edge
   sequence s_asis_first;
      tx_wr && tx_sop && tx_asis;
   endsequence
   property p_asis_first;
      @(posedge sys_clk) disable iff (!rst_n)
      s_asis_first |=> tx_no_pad[$past(tx_port)] && tx_no_crc[$past(tx_port)];
   endproperty
   a_asis_first: assert property (p_asis_first) // R1
      else $error("asis packet still padded or crc added");

   // last-word asis gives a one-cycle symbol error
   property p_sym_err;
      @(posedge sys_clk) disable iff (!rst_n)
      tx_wr && tx_eop && tx_asis |=> tx_sym_err[$past(tx_port)];
   endproperty
   a_sym_err: assert property (p_sym_err) // R2
      else $error("symbol error missing on asis last word");

   // abort with select flushes the selected port next cycle
   property p_flush;
      @(posedge sys_clk) disable iff (!rst_n)
      !rxsel_n && rx_abort |=> rx_flush[$past(rx_port)]
         ##1 (!rx_flush[$past(rx_port, 2)] || $past(!rxsel_n && rx_abort));
   endproperty
   a_flush: assert property (p_flush) // R4
      else $error("receive flush not issued on abort");

   // disabled report leaves tx ready lines undriven and low
   property p_tx_hiz;
      @(posedge sys_clk) disable iff (!rst_n)
      txctl_n |=> tx_rdy_oe == '0 && tx_rdy == '0;
   endproperty
   a_tx_hiz: assert property (p_tx_hiz) // R9
      else $error("tx ready driven while report disabled");

   // enabled report drives rx ready lines
   property p_rx_oe;
      @(posedge sys_clk) disable iff (!rst_n)
      rxctl_n ##1 !rxctl_n |=> rx_rdy_oe == '1 ##0 rx_rdy == $past(rxr_raw);
   endproperty
   a_rx_oe: assert property (p_rx_oe) // R10
      else $error("rx ready not driven while report enabled");

   // ahb slave never waits and never errors
   property p_ahb_okay;
      @(posedge sys_clk) disable iff (!rst_n)
      acc |=> hreadyout && !hresp;
   endproperty
   a_ahb_okay: assert property (p_ahb_okay)
      else $error("ahb slave stalled or errored");
endmodule

// ---- rtl/pfsc_unused_never.sv ----
// no logic here: the block lives in pfsc_top and pfsc_port

// ---- tb/pfsc_fifo_model.sv ----
// fifo fill model standing behind the eight ports
`timescale 1ns/1ps
module pfsc_fifo_model #(
   parameter int NPORT = 8,
   parameter int CNT_W = 9,
   parameter int DEPTH = 256
) (
   // clock and reset
   input wire logic sys_clk,
   input wire logic rst_n,
   // bus traffic seen by the fifos
   input wire logic tx_wr,
   input wire logic [2:0] tx_port,
   input wire logic rxsel_n,
   input wire logic [2:0] rx_port,
   input wire logic [NPORT-1:0] rx_flush,
   // direct load of one port's levels
   input wire logic ld,
   input wire logic [2:0] ld_port,
   input wire logic [CNT_W-1:0] ld_tx,
   input wire logic [CNT_W-1:0] ld_rx,
   // fill levels
   output logic [NPORT*CNT_W-1:0] tx_free,
   output logic [NPORT*CNT_W-1:0] rx_used
);
   logic [CNT_W-1:0] tf [NPORT];
   logic [CNT_W-1:0] ru [NPORT];
   // a word write eats four bytes, a read frees four, a flush empties
   always_ff @(posedge sys_clk) begin
      if (!rst_n) begin
         for (int i = 0; i < NPORT; i++) begin
            tf[i] <= CNT_W'(DEPTH);
            ru[i] <= '0;
         end
      end else begin
         if (tx_wr && tf[tx_port] >= CNT_W'(4))
            tf[tx_port] <= tf[tx_port] - CNT_W'(4);
         if (!rxsel_n && ru[rx_port] >= CNT_W'(4))
            ru[rx_port] <= ru[rx_port] - CNT_W'(4);
         for (int i = 0; i < NPORT; i++) begin
            if (rx_flush[i])
               ru[i] <= '0;
         end
         if (ld) begin
            tf[ld_port] <= ld_tx;
            ru[ld_port] <= ld_rx;
         end
      end
   end
   // flatten per-port levels onto the status buses
   always_comb begin
      for (int i = 0; i < NPORT; i++) begin
         tx_free[i*CNT_W+:CNT_W] = tf[i];
         rx_used[i*CNT_W+:CNT_W] = ru[i];
      end
   end
endmodule

// ---- tb/pfsc_top_tb_top.sv ----
// self-checking bench for the port sideband control block
`timescale 1ns/1ps
module pfsc_top_tb_top
   import pfsc_pkg::*;
;
   logic sys_clk, rst_n, hsel, hwrite, hreadyout, hresp, tx_wr, tx_sop;
   logic tx_eop, tx_asis, rxsel_n, rx_abort, txctl_n, rxctl_n, rx_fail, ld;
   logic [31:0] haddr, hwdata, hrdata, rd;
   logic [1:0] htrans;
   logic [2:0] tx_port, rx_port, ld_port;
   logic [7:0] tx_rdy, tx_rdy_oe, rx_rdy, rx_rdy_oe, rx_last_in, rx_hdr_in;
   logic [7:0] rx_err_drop, tx_stop_err, flow_req, tx_no_pad, tx_no_crc;
   logic [7:0] tx_sym_err, tx_mii_err, rx_flush, force_col, pause_req;
   logic [7:0] pause_zero;
   logic [15:0] pause_time;
   logic [71:0] tx_free, rx_used;
   logic [8:0] ld_tx, ld_rx;
   logic [11:0] mon;
   int miscompares, num_checks;
   // watched single bits, indexed by the wait tasks
   assign mon = {rx_fail, rx_flush[5], pause_zero[2], pause_req[2],
      force_col[1], tx_sym_err[0], tx_mii_err[0], tx_no_pad[0],
      tx_no_crc[0], tx_rdy_oe[0], rx_rdy[3], tx_rdy[0]};
   pfsc_top #(.NPORT(8), .CNT_W(9)) pfsc_top_inst (.sys_clk, .rst_n,
      .hsel, .haddr, .htrans, .hwrite, .hsize(3'h2), .hwdata,
      .hready(hreadyout), .hreadyout, .hresp, .hrdata, .tx_wr, .tx_port,
      .tx_sop, .tx_eop, .tx_asis, .rxsel_n, .rx_port, .rx_abort, .txctl_n,
      .rxctl_n, .tx_rdy, .tx_rdy_oe, .rx_rdy, .rx_rdy_oe, .rx_fail,
      .tx_free, .rx_used, .rx_last_in, .rx_hdr_in, .rx_err_drop,
      .tx_stop_err, .flow_req, .tx_no_pad, .tx_no_crc, .tx_sym_err,
      .tx_mii_err, .rx_flush, .force_col, .pause_req, .pause_zero,
      .pause_time);
   pfsc_fifo_model pfsc_fifo_model_inst (.sys_clk, .rst_n, .tx_wr,
      .tx_port, .rxsel_n, .rx_port, .rx_flush, .ld, .ld_port, .ld_tx,
      .ld_rx, .tx_free, .rx_used);
   // 50 mhz clock
   initial begin
      sys_clk = 1'b0;
      forever #10 sys_clk = ~sys_clk;
   end
   // counts, verdict and end of run
   task end_sim;
      $display("checks %0d mismatches %0d", num_checks, miscompares);
      if (miscompares == 0 && num_checks > 0) begin
         $display("NO MISMATCHES");
      end else begin
         $display("MISMATCHES SEEN");
      end
      $finish;
   endtask
   task chk(input logic [31:0] got, input logic [31:0] exp);
      num_checks++;
      if (got !== exp) begin
         miscompares++;
         $display("[FAIL] t=%0t got %h exp %h", $time, got, exp);
      end
   endtask
   // wait for the slave's ready at a rising edge, bounded
   task rdy;
      int n;
      n = 0;
      @(posedge sys_clk);
      while (hreadyout !== 1'b1) begin
         n++;
         if (n > 50) begin
            miscompares++;
            end_sim;
         end
         @(posedge sys_clk);
      end
   endtask
   // one single ahb-lite transfer, address then data phase
   task ahb(input logic w, input logic [7:0] a, input logic [31:0] d);
      @(posedge sys_clk);
      hsel <= 1'b1;
      haddr <= {24'h0, a};
      htrans <= 2'h2;
      hwrite <= w;
      rdy;
      hsel <= 1'b0;
      htrans <= 2'h0;
      hwrite <= 1'b0;
      hwdata <= d;
      rdy;
      rd = hrdata;
   endtask
   task rdchk(input logic [7:0] a, input logic [31:0] e);
      ahb(1'b0, a, 32'h0);
      chk(rd, e);
   endtask
   // wait up to 20 edges for a watched bit, then compare; bits are read
   // at a rising edge before it updates them, so callers stay on the edge
   task wb(input int i, input logic e);
      int n;
      for (n = 0; n < 20 && mon[i] !== e; n++) begin
         @(posedge sys_clk);
      end
      chk({31'h0, mon[i]}, {31'h0, e});
      if (n == 20)
         end_sim;
   endtask
   // a watched bit must still hold its value four cycles on
   task st(input int i, input logic e);
      repeat (4) @(posedge sys_clk);
      chk({31'h0, mon[i]}, {31'h0, e});
   endtask
   task ldp(input logic [2:0] p, input logic [8:0] t, input logic [8:0] r);
      @(posedge sys_clk);
      ld <= 1'b1;
      ld_port <= p;
      ld_tx <= t;
      ld_rx <= r;
      @(posedge sys_clk);
      ld <= 1'b0;
   endtask
   // one transmit word to port 0 with the as-is qualifier
   task tw(input logic s, input logic e);
      @(posedge sys_clk);
      tx_wr <= 1'b1;
      tx_port <= 3'd0;
      tx_sop <= s;
      tx_eop <= e;
      tx_asis <= 1'b1;
      @(posedge sys_clk);
      tx_wr <= 1'b0;
      tx_sop <= 1'b0;
      tx_eop <= 1'b0;
      tx_asis <= 1'b0;
   endtask
   // bounds the whole run
   initial begin
      repeat (20000) @(posedge sys_clk);
      miscompares++;
      end_sim;
   end
   // main sequence
   initial begin
      {rst_n, hsel, hwrite, tx_wr, tx_sop, tx_eop, tx_asis, rx_abort, ld,
         haddr, hwdata, htrans, tx_port, rx_port, ld_port, rx_last_in,
         rx_hdr_in, rx_err_drop, tx_stop_err, flow_req, ld_tx, ld_rx} = '0;
      {rxsel_n, txctl_n, rxctl_n} = 3'h7;
      miscompares = 0;
      num_checks = 0;
      repeat (6) @(posedge sys_clk);
      rst_n <= 1'b1;
      rdchk(ADDR_CFG0, CFG_RST);
      rdchk(ADDR_PAUSE, {16'h0, PAUSE_RST});
      ahb(1'b1, 8'h40, 32'hffff_ffff);
      rdchk(8'h40, 32'h0);
      ahb(1'b1, ADDR_PAUSE, 32'h0000_1234);
      rdchk(ADDR_PAUSE, 32'h0000_1234);
      $display("test registers done");
      txctl_n <= 1'b0;
      ldp(3'd0, 9'h040, 9'h0);
      wb(0, 1'b1);
      wb(2, 1'b1);
      ldp(3'd0, 9'h03f, 9'h0);
      wb(0, 1'b0);
      ldp(3'd0, 9'h040, 9'h0);
      wb(0, 1'b1);
      txctl_n <= 1'b1;
      wb(2, 1'b0);
      chk({31'h0, tx_rdy[0]}, 32'h0);
      txctl_n <= 1'b0;
      @(posedge sys_clk);
      tx_stop_err <= 8'h01;
      @(posedge sys_clk);
      tx_stop_err <= 8'h00;
      wb(0, 1'b0);
      st(0, 1'b0);
      rdchk(ADDR_TXERR, 32'h1);
      wb(0, 1'b1);
      rdchk(ADDR_TXERR, 32'h0);
      $display("test transmit ready done");
      wb(4, 1'b0);
      tw(1'b1, 1'b0);
      wb(4, 1'b1);
      wb(3, 1'b1);
      tw(1'b0, 1'b1);
      wb(6, 1'b1);
      wb(5, 1'b1);
      $display("test as-is done");
      rxctl_n <= 1'b0;
      ldp(3'd3, 9'h0, 9'h040);
      wb(1, 1'b1);
      chk({31'h0, rx_rdy_oe[3]}, 32'h1);
      ldp(3'd3, 9'h0, 9'h03f);
      wb(1, 1'b0);
      rx_last_in <= 8'h08;
      wb(1, 1'b1);
      rx_last_in <= 8'h00;
      wb(1, 1'b0);
      rx_hdr_in <= 8'h08;
      st(1, 1'b0);
      ahb(1'b1, ADDR_CFG0 + 8'h0c, 32'h6040_1040);
      wb(1, 1'b1);
      rx_hdr_in <= 8'h00;
      wb(1, 1'b0);
      @(posedge sys_clk);
      rx_err_drop <= 8'h08;
      @(posedge sys_clk);
      rx_err_drop <= 8'h00;
      wb(1, 1'b1);
      wb(11, 1'b1);
      @(posedge sys_clk);
      rxsel_n <= 1'b0;
      rx_port <= 3'd3;
      @(posedge sys_clk);
      rxsel_n <= 1'b1;
      wb(11, 1'b0);
      // abort together with the receive select flushes port 5
      @(posedge sys_clk);
      rxsel_n <= 1'b0;
      rx_abort <= 1'b1;
      rx_port <= 3'd5;
      @(posedge sys_clk);
      rxsel_n <= 1'b1;
      rx_abort <= 1'b0;
      wb(10, 1'b1);
      wb(10, 1'b0);
      $display("test receive done");
      flow_req <= 8'h02;
      wb(7, 1'b1);
      flow_req <= 8'h00;
      wb(7, 1'b0);
      ahb(1'b1, ADDR_CFG0 + 8'h08, 32'hf040_0040);
      flow_req <= 8'h04;
      wb(8, 1'b1);
      chk({16'h0, pause_time}, 32'h0000_1234);
      flow_req <= 8'h00;
      wb(9, 1'b1);
      $display("test flow control done");
      end_sim;
   end
endmodule
